/* common/clock_source_prescaler_x2_map.svh */
// Register offsets, field positions, reset values and counts of the clock block.
// Overview of operation
// R01: Source bit 1 crystal, 0 RC oscillator.
// R02: Source bit resets to 1; byte access only.
// R03: Reserved select bits read undefined; write zero.
// R04: Reload all ones divides by two.
// R05: Reload register eight bits, resets ones, byte-wide.
// R06: Divide factor is 512 minus twice reload.
// R07: Double speed bypasses prescaler, enables peripheral bits.
// R08: Source switch is synchronised, never glitches.
// R09: Peripheral bits ignored while double speed clear.
// R10: Under double speed: bit 0 six, 1 twelve.
// R11: Bit 6 selects watchdog rate.
// R12: Bit 5 selects counter array rate.
// R13: Bit 4 selects UART rate, modes 0, 2.
// R14: Bits 2, 1 select timer 1, timer 0.
// R15: New reload applies at next period boundary.
`ifndef CLOCK_SOURCE_PRESCALER_X2_MAP_SVH
`define CLOCK_SOURCE_PRESCALER_X2_MAP_SVH
`define CSP_ADDR_SRC_SEL 8'h85
`define CSP_ADDR_SPEED 8'h8f
`define CSP_ADDR_RELOAD 8'h97
`define CSP_RST_SRC_SEL 1'b1
`define CSP_RST_SPEED 8'h00
`define CSP_RST_RELOAD 8'hff
`define CSP_SPEED_MASK 8'h77
`define CSP_BIT_SRC 0
`define CSP_BIT_DOUBLE 0
`define CSP_BIT_TIMER0 1
`define CSP_BIT_TIMER1 2
`define CSP_BIT_UART 4
`define CSP_BIT_COUNTER 5
`define CSP_BIT_WDOG 6
`define CSP_DIV_BASE 10'd512
`define CSP_CYCLE_FAST 4'd5
`define CSP_CYCLE_LAST 4'd11
`define CSP_SYNC_TICKS 2'd2
`endif

/* common/clock_source_prescaler_x2_pkg.sv */
// Types shared by the clock selection and prescaler block.
package clock_source_prescaler_x2_pkg;
  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_SYNC
  } switch_state_t;
endpackage

/* verilog/clock_source_prescaler_x2.sv */
// Oscillator selection, prescaler and double-speed rate enables.
`timescale 1ns/1ns
`include "clock_source_prescaler_x2_map.svh"
module clock_source_prescaler_x2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic xtal_tick,
  input wire logic rc_tick,
  input wire logic [1:0] uart_mode,
  output logic oscillator_output,
  output logic osc_source_sel,
  output logic ck_tick,
  output logic cpu_cycle,
  output logic wdog_tick,
  output logic counter_array_tick,
  output logic uart_tick,
  output logic timer1_tick,
  output logic timer0_tick
);

  // Divide factor from a reload value; used by the prescaler and its reload-change cover.
  function automatic logic [9:0] div_factor(input logic [7:0] m);
    div_factor = `CSP_DIV_BASE - {1'b0, m, 1'b0};
  endfunction

  logic sel_reg, sel_next;
  logic [7:0] speed_reg, speed_next;
  logic [7:0] reload_reg, reload_next;
  logic [7:0] rdata_reg, rdata_next;
  logic act_reg, act_next;
  clock_source_prescaler_x2_pkg::switch_state_t sw_reg, sw_next;
  logic [1:0] sync_reg, sync_next;
  logic [9:0] div_reg, div_next;
  logic [9:0] cnt_reg, cnt_next;
  logic [3:0] phase_reg, phase_next;
  logic double_speed, act_tick, new_tick, fast_pt, slow_pt;

  // Register file; every write replaces the whole byte, there is no bit access.
  always_comb begin
    sel_next = sel_reg;
    speed_next = speed_reg;
    reload_next = reload_reg;
    rdata_next = rdata_reg;
    if (sfr_wr) begin
      unique case (sfr_addr)
        `CSP_ADDR_SRC_SEL: sel_next = sfr_wdata[`CSP_BIT_SRC]; // R02
        `CSP_ADDR_SPEED: speed_next = sfr_wdata & `CSP_SPEED_MASK;
        `CSP_ADDR_RELOAD: reload_next = sfr_wdata; // R05
        default: ;
      endcase
    end
    // Reserved bits of the select register read as zero here.
    if (sfr_rd) begin
      unique case (sfr_addr)
        `CSP_ADDR_SRC_SEL: rdata_next = {7'h00, sel_reg}; // R03
        `CSP_ADDR_SPEED: rdata_next = speed_reg;
        `CSP_ADDR_RELOAD: rdata_next = reload_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= `CSP_RST_SRC_SEL; // R02
      speed_reg <= `CSP_RST_SPEED;
      reload_reg <= `CSP_RST_RELOAD; // R05
      rdata_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      speed_reg <= speed_next;
      reload_reg <= reload_next;
      rdata_reg <= rdata_next;
    end
  end

  assign double_speed = speed_reg[`CSP_BIT_DOUBLE];
  assign sfr_rdata = rdata_reg;
  assign osc_source_sel = act_reg;

  // Source mux. A switch first lets the old oscillator finish its period,
  // then waits for two ticks of the new one, so no runt pulse escapes.
  assign act_tick = act_reg ? xtal_tick : rc_tick; // R01
  assign new_tick = sel_reg ? xtal_tick : rc_tick;
  assign oscillator_output =
    (sw_reg == clock_source_prescaler_x2_pkg::SW_RUN) && act_tick; // R08

  always_comb begin
    sw_next = sw_reg;
    act_next = act_reg;
    sync_next = sync_reg;
    unique case (sw_reg)
      clock_source_prescaler_x2_pkg::SW_RUN: begin
        if (sel_reg != act_reg) begin
          sw_next = clock_source_prescaler_x2_pkg::SW_DRAIN; // R08
        end
      end
      clock_source_prescaler_x2_pkg::SW_DRAIN: begin
        if (act_tick) begin
          sw_next = clock_source_prescaler_x2_pkg::SW_SYNC;
          sync_next = 2'd0;
        end
      end
      clock_source_prescaler_x2_pkg::SW_SYNC: begin
        if (new_tick) begin
          sync_next = sync_reg + 2'd1;
          if (sync_reg + 2'd1 == `CSP_SYNC_TICKS) begin
            act_next = sel_reg; // R08
            sw_next = clock_source_prescaler_x2_pkg::SW_RUN;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_reg <= clock_source_prescaler_x2_pkg::SW_RUN;
      act_reg <= `CSP_RST_SRC_SEL;
      sync_reg <= 2'd0;
    end else begin
      sw_reg <= sw_next;
      act_reg <= act_next;
      sync_reg <= sync_next;
    end
  end

  // Prescaler. The divide factor is only refreshed when a period ends, so a
  // reload write never shortens the period in flight.
  assign ck_tick = double_speed ? oscillator_output // R07
    : (oscillator_output && cnt_reg == div_reg - 10'd1); // R06

  always_comb begin
    cnt_next = cnt_reg;
    div_next = div_reg;
    if (oscillator_output) begin
      if (cnt_reg == div_reg - 10'd1) begin
        cnt_next = 10'd0;
        div_next = div_factor(reload_reg); // R15 R04
      end else begin
        cnt_next = cnt_reg + 10'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 10'd0;
      div_reg <= 10'd2;
    end else begin
      cnt_reg <= cnt_next;
      div_reg <= div_next;
    end
  end

  // Cycle phase: six prescaled ticks for the standard rate, twelve for slow.
  always_comb begin
    phase_next = phase_reg;
    if (ck_tick) begin
      phase_next = (phase_reg == `CSP_CYCLE_LAST) ? 4'd0 : phase_reg + 4'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 4'd0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign fast_pt = ck_tick && (phase_reg == `CSP_CYCLE_FAST ||
    phase_reg == `CSP_CYCLE_LAST);
  assign slow_pt = ck_tick && phase_reg == `CSP_CYCLE_LAST;
  assign cpu_cycle = fast_pt; // R07

  // A peripheral bit only matters under double speed; else standard rate.
  // Every input is an argument, so a continuous assignment that calls this
  // is woken by each pulse and not only by a change of the speed bit.
  function automatic logic rate_pt(input logic dbl, input logic bit_set,
    input logic fast, input logic slow);
    rate_pt = (dbl && bit_set) ? slow : fast;
  endfunction

  assign wdog_tick = rate_pt(double_speed, speed_reg[`CSP_BIT_WDOG],
    fast_pt, slow_pt); // R09 R10 R11
  assign counter_array_tick = rate_pt(double_speed,
    speed_reg[`CSP_BIT_COUNTER], fast_pt, slow_pt); // R12
  // Only synchronous modes 0 and 2 follow the UART speed bit.
  assign uart_tick = uart_mode[0] ? fast_pt
    : rate_pt(double_speed, speed_reg[`CSP_BIT_UART],
      fast_pt, slow_pt); // R13
  assign timer1_tick = rate_pt(double_speed, speed_reg[`CSP_BIT_TIMER1],
    fast_pt, slow_pt); // R14
  assign timer0_tick = rate_pt(double_speed, speed_reg[`CSP_BIT_TIMER0],
    fast_pt, slow_pt); // R14

  chk_src_after_reset: assert property (@(posedge clk) // R02
    $fell(rst) |-> act_reg && sel_reg)
    else $error("Source is not crystal after reset.");
  chk_src_mux_route: assert property (@(posedge clk) disable iff (rst) // R01
    sw_reg == clock_source_prescaler_x2_pkg::SW_RUN && sel_reg == act_reg
    |-> oscillator_output == (sel_reg ? xtal_tick : rc_tick))
    else $error("Oscillator output from wrong source.");
  chk_rsv_read_zero: assert property (@(posedge clk) disable iff (rst) // R03
    sfr_rd && sfr_addr == `CSP_ADDR_SRC_SEL |=> sfr_rdata[7:1] == 7'h00)
    else $error("Reserved select bits read nonzero.");
  chk_reload_write: assert property (@(posedge clk) disable iff (rst) // R05
    sfr_wr && sfr_addr == `CSP_ADDR_RELOAD |=> reload_reg == $past(sfr_wdata))
    else $error("Reload write not stored.");
  chk_div_factor: assert property (@(posedge clk) disable iff (rst) // R06
    !double_speed && oscillator_output && cnt_reg == div_reg - 10'd1
    |=> div_reg == `CSP_DIV_BASE - {1'b0, $past(reload_reg), 1'b0}
      && cnt_reg == 10'd0)
    else $error("Prescaler period not 512 minus twice reload.");
  chk_reload_boundary: assert property (@(posedge clk) disable iff (rst) // R15
    !(oscillator_output && cnt_reg == div_reg - 10'd1) |=> $stable(div_reg))
    else $error("Divide factor changed mid period.");
  chk_x2_bypass: assert property (@(posedge clk) disable iff (rst) // R07
    double_speed |-> ck_tick == oscillator_output)
    else $error("Double speed did not bypass prescaler.");
  chk_switch_quiet: assert property (@(posedge clk) disable iff (rst) // R08
    sw_reg != clock_source_prescaler_x2_pkg::SW_RUN |-> !oscillator_output)
    else $error("Clock passed during source switch.");
  chk_std_rate: assert property (@(posedge clk) disable iff (rst) // R09
    !double_speed |-> wdog_tick == cpu_cycle && timer0_tick == cpu_cycle)
    else $error("Peripheral rate differs in standard mode.");
  chk_slow_rate: assert property (@(posedge clk) disable iff (rst) // R10
    double_speed && speed_reg[`CSP_BIT_WDOG] && wdog_tick
    |-> phase_reg == `CSP_CYCLE_LAST)
    else $error("Twelve-period rate ticked early.");

  cov_source_switch: cover property (@(posedge clk) disable iff (rst)
    sw_reg == clock_source_prescaler_x2_pkg::SW_SYNC ##1
    sw_reg == clock_source_prescaler_x2_pkg::SW_RUN);
  cov_reload_change: cover property (@(posedge clk) disable iff (rst)
    ck_tick && !double_speed && div_reg != div_factor(reload_reg));
  cov_slow_timer: cover property (@(posedge clk) disable iff (rst)
    double_speed && speed_reg[`CSP_BIT_TIMER1] && timer1_tick);

endmodule

/* bench/testbench.sv */
// Self-checking bench for the clock selection and prescaler block.
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, rnd = 0;
  logic xtal_tick = 1, rc_tick = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, v;
  logic [7:0] rl [3] = '{8'hfe, 8'h00, 8'h00};
  logic [1:0] uart_mode = 0;
  logic oscillator_output, osc_source_sel, ck_tick, cpu_cycle;
  wire [4:0] rate;
  wire [6:0] outs = {cpu_cycle, ck_tick, rate};
  int error_cnt = 0, total_checks = 0, cyc = 0, n;

  clock_source_prescaler_x2 dut_u (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xtal_tick(xtal_tick), .rc_tick(rc_tick),
    .uart_mode(uart_mode), .oscillator_output(oscillator_output),
    .osc_source_sel(osc_source_sel), .ck_tick(ck_tick), .cpu_cycle(cpu_cycle),
    .wdog_tick(rate[4]), .counter_array_tick(rate[3]), .uart_tick(rate[2]),
    .timer1_tick(rate[1]), .timer0_tick(rate[0]));

  // Free-running 50 MHz clock.
  initial forever #10 clk = ~clk;

  // Steady crystal makes period counts exact; random ticks test the switch.
  always @(posedge clk) begin
    #1;
    xtal_tick <= rnd ? 1'($urandom) : 1'b1;
    rc_tick <= rnd ? 1'($urandom) : 1'b0;
  end

  // Hang guard; the longest period is 512 cycles, so this is generous.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Byte write; the strobe stands for exactly one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge clk) #1;
    sfr_wr = 0;
  endtask

  // Byte read; data is registered, so it is compared one cycle on.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1;
    @(posedge clk) #1;
    sfr_rd = 0;
    chk(sfr_rdata, exp);
  endtask

  // Cycles between two pulses of one output; a negative figure only syncs.
  task automatic gap(input int k, input int exp);
    int c;
    @(negedge clk);
    for (c = 0; c < 2000 && outs[k] !== 1'b1; c++) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (outs[k] !== 1'b1 && n < 2000);
    if (exp >= 0) chk(16'(n), 16'(exp));
  endtask

  initial begin
    void'($urandom(32'h83a9ba93));
    repeat (3) @(posedge clk);
    #1 rst = 0;
    rd(8'h85, 8'h01);
    rd(8'h8f, 8'h00);
    rd(8'h97, 8'hff);
    rd(8'h3c, 8'h00);
    $display("reset values done");
    // Peripheral bits set at random must not matter without double speed.
    v = 8'($urandom) & 8'h76;
    wr(8'h8f, v);
    rd(8'h8f, v);
    gap(5, 2);
    gap(4, 12);
    gap(0, 12);
    $display("standard rate done");
    // Reload changes are measured one whole period after the write.
    rl[2] = 8'($urandom);
    foreach (rl[i]) begin
      wr(8'h97, rl[i]);
      rd(8'h97, rl[i]);
      gap(5, -1);
      gap(5, 512 - 2 * rl[i]);
    end
    $display("prescaler done");
    // Double speed with all peripheral bits clear, then all set.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #1;
      uart_mode = i ? 2'd2 : 2'd0;
      wr(8'h8f, i ? 8'h77 : 8'h01);
      gap(5, 1);
      gap(6, 6);
      for (int k = 0; k < 5; k++) gap(k, i ? 12 : 6);
      // Asynchronous UART modes ignore the UART speed bit.
      if (i == 1) begin
        @(posedge clk) #1;
        uart_mode = {1'($urandom), 1'b1};
        gap(2, 6);
      end
    end
    $display("double speed done");
    // Switch to RC and back while both oscillators tick at random.
    rnd = 1;
    for (int s = 0; s < 2; s++) begin
      wr(8'h85, s ? 8'h01 : 8'h00);
      for (n = 0; n < 100 && osc_source_sel !== 1'(s); n++) @(negedge clk);
      chk(osc_source_sel, 16'(s));
      repeat (20) begin
        @(negedge clk);
        chk(oscillator_output, s ? xtal_tick : rc_tick);
      end
      rd(8'h85, 8'(s));
    end
    $display("source switch done");
    end_of_test();
  end
endmodule
